// file: cfgb_bank.sv
// Channel configuration register bank with the channel-three phase delay line.
// Assumes the control port decoder presents one access per cycle, synchronous
// to clk_sys, and that mod_tick marks one modulator clock period.
// How it works
// - Nonzero channel-three code N delays samples by N modulator periods, zero none.
// - Channel-three delay register: page zero, index 0x4A, eight bits, RW, resets zero.
// - Channel-four bit 7 clear means microphone, set means line input.
// - Bits 6:5 pick differential, single-ended or PDM source; code 3 reserved.
// - Bit 4 clear means AC coupling, set means direct coupling.
// - Bits 3:2 select 2.5, 10 or 20 kilohm load; code 3 reserved.
// - Bit 0 enables range enhancer or level control, chosen by register 108 bit 3.
// - Channel-four input register at 0x4B resets to zero.
// - Gain register 0x4C holds 6-bit gain in bits 7:2, 0 to 42 dB.
// - Volume register 0x4D: 0 mutes, 1 is -100 dB, 201 is 0 dB.
// - Volume register resets to 0xC9, unity volume.
`timescale 1ns/1ps
`include "cfgb_consts.svh"

module cfgb_bank
  import cfgb_pkg::*;
#(
  parameter int SAMPLE_W = 4,
  parameter int DELAY_DEPTH = 256
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  // Control port
  input wire cfgb_req_t reg_req,
  output logic [7:0] reg_rdata,
  // Shared selection of range enhancer versus level control
  input wire logic page0_reg_108_bit3,
  // Channel-three modulator stream
  input wire logic mod_tick,
  input wire logic [SAMPLE_W-1:0] ch3_sample_in,
  output logic [SAMPLE_W-1:0] ch3_sample_out,
  // Channel settings
  output logic [7:0] ch3_phase_delay_code,
  output cfgb_ch4_cfg_t ch4_cfg
);

  localparam int PTR_W = $clog2(DELAY_DEPTH);

  logic [7:0] ch3_phase_delay_q;
  logic [7:0] ch4_input_setup_q;
  logic [7:0] ch4_analog_gain_q;
  logic [7:0] ch4_volume_level_q;
  logic [SAMPLE_W-1:0] dly_mem_q [DELAY_DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [SAMPLE_W-1:0] ch3_out_q;
  logic [7:0] rdata_d;

  function automatic logic wr_hit(input cfgb_req_t r, input logic [7:0] ofs);
    wr_hit = r.sel && r.we && (r.page == `CFGB_PAGE_CFG) && (r.addr == ofs);
  endfunction : wr_hit

  // Half-dB steps relative to unity; code 0 is mute and handled apart
  function automatic logic signed [8:0] vol_half_db(input logic [7:0] code);
    vol_half_db = $signed({1'b0, code}) - $signed({1'b0, `CFGB_VOL_UNITY_CODE});
  endfunction : vol_half_db

  // Register storage; reserved bits are never stored
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ch3_phase_delay_q <= `CFGB_RST_CH3_PHASE;
      ch4_input_setup_q <= `CFGB_RST_CH4_INPUT;
      ch4_analog_gain_q <= `CFGB_RST_CODE_A;
      ch4_volume_level_q <= `CFGB_RST_CH4_VOLUME;
    end else if (clk_en) begin
      if (wr_hit(reg_req, `CFGB_OFS_CH3_PHASE)) begin
        ch3_phase_delay_q <= reg_req.wdata;
      end
      if (wr_hit(reg_req, `CFGB_OFS_CH4_INPUT)) begin
        ch4_input_setup_q <= reg_req.wdata & `CFGB_MASK_CH4_INPUT;
      end
      if (wr_hit(reg_req, `CFGB_OFS_CODE_A)) begin
        ch4_analog_gain_q <= reg_req.wdata & `CFGB_MASK_CODE_A;
      end
      if (wr_hit(reg_req, `CFGB_OFS_CH4_VOLUME)) begin
        ch4_volume_level_q <= reg_req.wdata;
      end
    end
  end

  // Read mux; other pages and indices answer zero
  always_comb begin
    rdata_d = 8'h00;
    if (reg_req.sel && !reg_req.we && reg_req.page == `CFGB_PAGE_CFG) begin
      unique case (reg_req.addr)
        `CFGB_OFS_CH3_PHASE: rdata_d = ch3_phase_delay_q;
        `CFGB_OFS_CH4_INPUT: rdata_d = ch4_input_setup_q;
        `CFGB_OFS_CODE_A: rdata_d = ch4_analog_gain_q;
        `CFGB_OFS_CH4_VOLUME: rdata_d = ch4_volume_level_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Read data is held until the next read
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en && reg_req.sel && !reg_req.we) begin
      reg_rdata <= rdata_d;
    end
  end

  // Delay line: every tick stores a sample and picks the one N ticks old
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_q <= '0;
      ch3_out_q <= '0;
    end else if (clk_en && mod_tick) begin
      wr_ptr_q <= wr_ptr_q + PTR_W'(1);
      if (ch3_phase_delay_q == 8'h00) begin
        ch3_out_q <= ch3_sample_in;
      end else begin
        ch3_out_q <= dly_mem_q[wr_ptr_q - PTR_W'(ch3_phase_delay_q)];
      end
    end
  end

  // Memory has no reset; stale taps can show until every entry is written, DELAY_DEPTH ticks after reset
  always_ff @(posedge clk_sys) begin
    if (clk_en && mod_tick) begin
      dly_mem_q[wr_ptr_q] <= ch3_sample_in;
    end
  end

  assign ch3_sample_out = ch3_out_q;
  assign ch3_phase_delay_code = ch3_phase_delay_q;

  // Decoded channel-four view
  always_comb begin
    ch4_cfg.line_input = ch4_input_setup_q[`CFGB_POS_CLASS];
    ch4_cfg.source = cfgb_src_t'(
      ch4_input_setup_q[`CFGB_POS_SRC_HI:`CFGB_POS_SRC_LO]);
    ch4_cfg.direct_coupling = ch4_input_setup_q[`CFGB_POS_COUPLING];
    ch4_cfg.load_select = ch4_input_setup_q[`CFGB_POS_LOAD_HI:`CFGB_POS_LOAD_LO];
    // Pin muxing stays with software, so the PDM pick is passed on as is
    ch4_cfg.range_enhancer_on = ch4_input_setup_q[`CFGB_POS_RANGE_EN]
      && !page0_reg_108_bit3;
    ch4_cfg.automatic_level_control_on = ch4_input_setup_q[`CFGB_POS_RANGE_EN]
      && page0_reg_108_bit3;
    ch4_cfg.gain_db = ch4_analog_gain_q[`CFGB_POS_GAIN_HI:`CFGB_POS_GAIN_LO];
    ch4_cfg.gain_reserved = ch4_cfg.gain_db > `CFGB_GAIN_MAX_CODE;
    ch4_cfg.muted = ch4_volume_level_q == `CFGB_VOL_MUTE_CODE;
    ch4_cfg.volume_half_db = vol_half_db(ch4_volume_level_q);
    ch4_cfg.code_reserved = (ch4_cfg.source == CFGB_SRC_RSVD)
      || (ch4_cfg.load_select == `CFGB_RESERVED_CODE2);
  end

  a_phase_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    (clk_en && wr_hit(reg_req, `CFGB_OFS_CH3_PHASE))
      |=> ch3_phase_delay_code == $past(reg_req.wdata))
    else $error("Phase delay write not stored");

  a_reserved_read: assert property (@(posedge clk_sys) disable iff (!nrst)
    (clk_en && reg_req.sel && !reg_req.we && reg_req.page == `CFGB_PAGE_CFG
      && reg_req.addr == `CFGB_OFS_CODE_A) |=> reg_rdata[1:0] == 2'h0)
    else $error("Reserved gain bits read nonzero");

  a_input_reserved: assert property (@(posedge clk_sys) disable iff (!nrst)
    (clk_en && reg_req.sel && !reg_req.we && reg_req.page == `CFGB_PAGE_CFG
      && reg_req.addr == `CFGB_OFS_CH4_INPUT)
      |=> (reg_rdata == $past(ch4_input_setup_q)) && (reg_rdata[1] == 1'b0))
    else $error("Input register readback wrong");

  a_reset_values: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(nrst) |-> (ch4_volume_level_q == 8'hc9 && ch4_input_setup_q == 8'h00
      && ch3_phase_delay_q == 8'h00 && ch4_cfg.volume_half_db == 9'sd0))
    else $error("Reset values wrong");

  a_volume_scale: assert property (@(posedge clk_sys) disable iff (!nrst)
    ch4_volume_level_q == 8'h01 |-> (ch4_cfg.volume_half_db == -9'sd200
      && !ch4_cfg.muted))
    else $error("Volume code one is not minus 100 dB");

  a_volume_mute: assert property (@(posedge clk_sys) disable iff (!nrst)
    ch4_cfg.muted == (ch4_volume_level_q == 8'h00))
    else $error("Mute flag disagrees with volume code");

  a_range_select: assert property (@(posedge clk_sys) disable iff (!nrst)
    !(ch4_cfg.range_enhancer_on && ch4_cfg.automatic_level_control_on)
      && ((ch4_cfg.range_enhancer_on || ch4_cfg.automatic_level_control_on)
        == ch4_input_setup_q[0]))
    else $error("Range enhancer and level control select wrong");

  a_gain_reserved: assert property (@(posedge clk_sys) disable iff (!nrst)
    ch4_cfg.gain_reserved == (ch4_analog_gain_q[7:2] >= 6'd43))
    else $error("Gain reserved flag wrong");

  a_delay_bypass: assert property (@(posedge clk_sys) disable iff (!nrst)
    (clk_en && mod_tick && ch3_phase_delay_q == 8'h00)
      |=> ch3_sample_out == $past(ch3_sample_in))
    else $error("Zero delay did not pass sample through");

  a_delay_one: assert property (@(posedge clk_sys) disable iff (!nrst)
    (clk_en && mod_tick && ch3_phase_delay_q == 8'h01)
      |=> ch3_sample_out == $past(dly_mem_q[wr_ptr_q - PTR_W'(1)]))
    else $error("Single period delay wrong");

  a_field_decode: assert property (@(posedge clk_sys) disable iff (!nrst)
    (ch4_cfg.line_input == ch4_input_setup_q[7])
      && (ch4_cfg.direct_coupling == ch4_input_setup_q[4])
      && (ch4_cfg.code_reserved == (ch4_input_setup_q[6:5] == 2'h3
        || ch4_input_setup_q[3:2] == 2'h3)))
    else $error("Input field decode wrong");

  // Enable low must hold every flop; a write presented while it is low is dropped
  a_clken_freeze: assert property (@(posedge clk_sys) disable iff (!nrst)
    !clk_en |=> ($stable(ch3_phase_delay_q) && $stable(ch4_input_setup_q)
      && $stable(ch4_analog_gain_q) && $stable(ch4_volume_level_q)
      && $stable(reg_rdata) && $stable(wr_ptr_q) && $stable(ch3_sample_out)))
    else $error("State changed while clock enable low");

  a_input_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    (clk_en && wr_hit(reg_req, `CFGB_OFS_CH4_INPUT))
      |=> ch4_input_setup_q == ($past(reg_req.wdata) & 8'hfd))
    else $error("Input register write not stored");

  a_gain_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    (clk_en && wr_hit(reg_req, `CFGB_OFS_CODE_A))
      |=> ch4_analog_gain_q == ($past(reg_req.wdata) & 8'hfc))
    else $error("Gain register write not stored");

  a_volume_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    (clk_en && wr_hit(reg_req, `CFGB_OFS_CH4_VOLUME))
      |=> ch4_volume_level_q == $past(reg_req.wdata))
    else $error("Volume register write not stored");

  // Writes to other pages must not alias onto this bank
  a_foreign_page: assert property (@(posedge clk_sys) disable iff (!nrst)
    (clk_en && reg_req.sel && reg_req.we && reg_req.page != 8'h00)
      |=> ($stable(ch3_phase_delay_q) && $stable(ch4_input_setup_q)
        && $stable(ch4_analog_gain_q) && $stable(ch4_volume_level_q)))
    else $error("Write to another page changed a register");

  a_unmapped_read: assert property (@(posedge clk_sys) disable iff (!nrst)
    (clk_en && reg_req.sel && !reg_req.we && (reg_req.page != 8'h00
      || reg_req.addr < 8'h4a || reg_req.addr > 8'h4d))
      |=> reg_rdata == 8'h00)
    else $error("Unmapped read returned nonzero");

  a_read_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    !(clk_en && reg_req.sel && !reg_req.we) |=> $stable(reg_rdata))
    else $error("Read data moved without a read");

  a_tap_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    !(clk_en && mod_tick) |=> $stable(ch3_sample_out))
    else $error("Delayed sample moved without a tick");

  a_ptr_step: assert property (@(posedge clk_sys) disable iff (!nrst)
    (clk_en && mod_tick) |=> wr_ptr_q == $past(wr_ptr_q) + PTR_W'(1))
    else $error("Delay pointer did not advance");

  a_gain_decode: assert property (@(posedge clk_sys) disable iff (!nrst)
    ch4_cfg.gain_db == ch4_analog_gain_q[7:2])
    else $error("Gain field decode wrong");

  // Top code is +27 dB, i.e. 54 half-dB steps above unity
  a_volume_top: assert property (@(posedge clk_sys) disable iff (!nrst)
    ch4_volume_level_q == 8'hff |-> (ch4_cfg.volume_half_db == 9'sd54
      && !ch4_cfg.muted))
    else $error("Volume code 255 is not plus 27 dB");

  a_volume_unity: assert property (@(posedge clk_sys) disable iff (!nrst)
    ch4_volume_level_q == 8'hc9 |-> ch4_cfg.volume_half_db == 9'sd0)
    else $error("Volume code 201 is not unity");

  a_source_decode: assert property (@(posedge clk_sys) disable iff (!nrst)
    (ch4_cfg.source == cfgb_src_t'(ch4_input_setup_q[6:5]))
      && (ch4_cfg.load_select == ch4_input_setup_q[3:2]))
    else $error("Source or load decode wrong");

  // Reserved bits must never be stored, whatever the host writes
  a_reserved_store: assert property (@(posedge clk_sys) disable iff (!nrst)
    (ch4_input_setup_q[1] == 1'b0) && (ch4_analog_gain_q[1:0] == 2'h0))
    else $error("Reserved bit stored");

  a_coupling_decode: assert property (@(posedge clk_sys) disable iff (!nrst)
    ch4_cfg.direct_coupling == ch4_input_setup_q[4])
    else $error("Coupling decode wrong");

  a_class_decode: assert property (@(posedge clk_sys) disable iff (!nrst)
    ch4_cfg.line_input == ch4_input_setup_q[7])
    else $error("Input class decode wrong");

endmodule : cfgb_bank

// file: cfgb_consts.svh
// Constants of the channel configuration register bank.
// Included by the bank; definitions only.
`ifndef CFGB_CONSTS_SVH
`define CFGB_CONSTS_SVH

`define CFGB_PAGE_CFG 8'h00
`define CFGB_OFS_CH3_PHASE 8'h4a
`define CFGB_OFS_CH4_INPUT 8'h4b
`define CFGB_OFS_CODE_A 8'h4c
`define CFGB_OFS_CH4_VOLUME 8'h4d

`define CFGB_RST_CH3_PHASE 8'h00
`define CFGB_RST_CH4_INPUT 8'h00
`define CFGB_RST_CODE_A 8'h00
`define CFGB_RST_CH4_VOLUME 8'hc9

// Writable bits; the rest are reserved
`define CFGB_MASK_CH4_INPUT 8'hfd
`define CFGB_MASK_CODE_A 8'hfc

`define CFGB_POS_CLASS 7
`define CFGB_POS_SRC_HI 6
`define CFGB_POS_SRC_LO 5
`define CFGB_POS_COUPLING 4
`define CFGB_POS_LOAD_HI 3
`define CFGB_POS_LOAD_LO 2
`define CFGB_POS_RANGE_EN 0
`define CFGB_POS_GAIN_HI 7
`define CFGB_POS_GAIN_LO 2

`define CFGB_GAIN_MAX_CODE 6'h2a
`define CFGB_VOL_UNITY_CODE 8'hc9
`define CFGB_VOL_MUTE_CODE 8'h00
`define CFGB_RESERVED_CODE2 2'h3

`endif

// file: cfgb_pkg.sv
// Types shared by the channel configuration register bank.
// Assumes cfgb_consts.svh is on the include path.
package cfgb_pkg;

  typedef enum logic [1:0] {
    CFGB_SRC_DIFF = 2'b00,
    CFGB_SRC_SINGLE = 2'b01,
    CFGB_SRC_PDM = 2'b10,
    CFGB_SRC_RSVD = 2'b11
  } cfgb_src_t;

  // Decoded channel-four settings for the datapath
  typedef struct packed {
    logic line_input;
    cfgb_src_t source;
    logic direct_coupling;
    logic [1:0] load_select;
    logic range_enhancer_on;
    logic automatic_level_control_on;
    logic [5:0] gain_db;
    logic gain_reserved;
    logic muted;
    logic signed [8:0] volume_half_db;
    logic code_reserved;
  } cfgb_ch4_cfg_t;

  // Host side register access on the control port
  typedef struct packed {
    logic sel;
    logic we;
    logic [7:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cfgb_req_t;

endpackage : cfgb_pkg

// file: tb_top.sv
// Self-checking testbench for the channel configuration register bank.
// Drives the control port and the channel-three stream itself, at the falling edge.
`timescale 1ns/1ps
module tb_top;
  import cfgb_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic clk_en = 1'b1;
  cfgb_req_t reg_req = '0;
  logic [7:0] reg_rdata;
  logic page0_reg_108_bit3 = 1'b0;
  logic mod_tick = 1'b0;
  logic [3:0] s_in = 4'h0;
  logic [3:0] s_out;
  logic [7:0] ph_code;
  cfgb_ch4_cfg_t cfg;
  int fails = 0;
  int n_compared = 0;

  always #2 clk_sys = ~clk_sys;

  cfgb_bank #(.SAMPLE_W(4), .DELAY_DEPTH(256)) uut (
    .clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .page0_reg_108_bit3(page0_reg_108_bit3),
    .mod_tick(mod_tick), .ch3_sample_in(s_in), .ch3_sample_out(s_out),
    .ch3_phase_delay_code(ph_code), .ch4_cfg(cfg));

  task automatic chk(string what, logic [8:0] exp, logic [8:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Request held across the sampling edge, released at the next falling edge
  task automatic acc(logic we, logic [7:0] pg, logic [7:0] a, logic [7:0] d);
    @(negedge clk_sys);
    reg_req = '{1'b1, we, pg, a, d};
    @(negedge clk_sys);
    reg_req.sel = 1'b0;
  endtask : acc

  task automatic rd(logic [7:0] a, logic [7:0] exp);
    acc(1'b0, 8'h00, a, 8'h00);
    chk($sformatf("reg %h", a), {1'b0, exp}, {1'b0, reg_rdata});
  endtask : rd

  task automatic t_reset();
    rd(8'h4a, 8'h00);
    rd(8'h4b, 8'h00);
    rd(8'h4c, 8'h00);
    rd(8'h4d, 8'hc9);
    chk("unity", 9'h000, cfg.volume_half_db);
    $display("test reset done");
  endtask : t_reset

  task automatic t_access();
    for (int a = 8'h4a; a <= 8'h4d; a++) acc(1'b1, 8'h00, 8'(a), 8'hff);
    rd(8'h4a, 8'hff);
    rd(8'h4b, 8'hfd);
    rd(8'h4c, 8'hfc);
    rd(8'h4d, 8'hff);
    chk("src rsvd", 9'h001, cfg.code_reserved);
    acc(1'b1, 8'h01, 8'h4a, 8'h00);
    rd(8'h4a, 8'hff);
    rd(8'h4e, 8'h00);
    // Enable low: the write must be lost
    clk_en = 1'b0;
    acc(1'b1, 8'h00, 8'h4a, 8'h00);
    clk_en = 1'b1;
    rd(8'h4a, 8'hff);
    acc(1'b1, 8'h00, 8'h4c, 8'ha8);
    chk("gain 42", 9'h02a, cfg.gain_db);
    chk("gain ok", 9'h000, cfg.gain_reserved);
    acc(1'b1, 8'h00, 8'h4c, 8'hac);
    chk("gain 43", 9'h001, cfg.gain_reserved);
    $display("test access done");
  endtask : t_access

  task automatic t_input();
    logic [1:0] k;
    logic en;
    for (int i = 0; i < 3; i++) begin
      k = 2'(i);
      en = ~k[1];
      page0_reg_108_bit3 = k[0];
      // Shared pins are assumed set up by software before each source pick
      acc(1'b1, 8'h00, 8'h4b, {k[0], k, ~k[0], k, 1'b0, en});
      chk("class", {8'h00, k[0]}, cfg.line_input);
      chk("source", {7'h00, k}, cfg.source);
      chk("coupling", {8'h00, ~k[0]}, cfg.direct_coupling);
      chk("load", {7'h00, k}, cfg.load_select);
      chk("enhance", {8'h00, en & ~k[0]}, cfg.range_enhancer_on);
      chk("level", {8'h00, en & k[0]}, cfg.automatic_level_control_on);
      chk("no rsvd", 9'h000, cfg.code_reserved);
    end
    $display("test input done");
  endtask : t_input

  task automatic t_volume();
    logic [7:0] codes [6] = '{8'h00, 8'h01, 8'h02, 8'hc9, 8'hca, 8'hff};
    foreach (codes[i]) begin
      acc(1'b1, 8'h00, 8'h4d, codes[i]);
      chk("mute", {8'h00, codes[i] == 8'h00}, cfg.muted);
      chk("half db", {1'b0, codes[i]} - 9'd201, cfg.volume_half_db);
    end
    $display("test volume done");
  endtask : t_volume

  task automatic t_delay(logic [7:0] n, int cnt);
    acc(1'b1, 8'h00, 8'h4a, n);
    chk("code", {1'b0, n}, {1'b0, ph_code});
    for (int i = 1; i <= cnt; i++) begin
      @(negedge clk_sys);
      mod_tick = 1'b1;
      s_in = 4'(i);
      @(negedge clk_sys);
      mod_tick = 1'b0;
      if (i > n) chk("tap", {5'h00, 4'(i - n)}, {5'h00, s_out});
    end
    $display("test delay %0d done", n);
  endtask : t_delay

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done

  initial begin
    repeat (16) @(negedge clk_sys);
    nrst = 1'b1;
    t_reset();
    t_access();
    t_input();
    t_volume();
    t_delay(8'h00, 4);
    t_delay(8'h02, 8);
    t_delay(8'hff, 260);
    test_done();
  end

  // Whole run is under 1000 cycles; this cuts a hang short
  initial begin
    #20000;
    fails++;
    $display("[ERR] watchdog expected done seen hang");
    test_done();
  end
endmodule : tb_top
